// File: hw/cmp_pkg.sv
package cmp_pkg;
    // ---------------------------------------------------------------
    // File register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
    localparam logic [7:0] ADDR_ENABLES = 8'h8c;
    localparam logic [7:0] ADDR_CMPCTL  = 8'h1f;
    localparam logic [7:0] ADDR_VREF    = 8'h9f;
    localparam logic [7:0] ADDR_DATA_A  = 8'h05;
    localparam logic [7:0] ADDR_DIR_A   = 8'h85;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CMP_IRQ_BIT   = 6;
    localparam int CMP1_OUT_BIT  = 6;
    localparam int CMP2_OUT_BIT  = 7;
    localparam int CIS_BIT       = 3;
    localparam int VREF_RSV_BIT  = 4;

    // ---------------------------------------------------------------
    // Reset values and comparator mode codes
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_FLAGS   = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [3:0] RST_CMPCTL  = 4'h0;
    localparam logic [7:0] RST_VREF    = 8'h00;
    localparam logic [4:0] RST_DIR_A   = 5'h1f;
    localparam logic [2:0] MODE_OUTPUTS = 3'h6;
    localparam logic [2:0] MODE_OFF     = 3'h7;
    localparam logic [2:0] MODE_RESET   = 3'h0;
endpackage

// File: hw/cmp_sync_if.sv
`timescale 1ns/100ps
interface cmp_sync_if;
    logic [1:0] raw;
    logic [1:0] stable;
    modport src (output raw, input stable);
    modport sync (input raw, output stable);
endinterface

// File: hw/cmp_sync.sv
`timescale 1ns/100ps
module cmp_sync
    import cmp_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Levels
    cmp_sync_if.sync  port
);
    // ---------------------------------------------------------------
    // Three-stage sampler; a change is taken once stages 2 and 3 agree
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;

    if (WIDTH != 2) begin : g_width_check
        $error("cmp_sync serves two comparators only");
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= port.raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                held[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
                held[i] <= s3[i];
            end
        end
    end

    assign port.stable = held;
endmodule

// File: hw/comparator_output_interrupt.sv
// How it works
// (R1) Enable bit 6, read/write, resets 0
// (R2) Flag bit 6, read/write, resets 0
// (R3) Flag sets regardless of any enable
// (R4) Software clears flag before enabling
// (R5) Other bits read zero, ignore writes
// (R6) Flags at 0Ch, enables at 8Ch
// (R7) Comparator outputs read-only in control
// (R8) Mode 110 drives raw outputs to pins
// (R9) Direction bits still gate pin drivers
// (R10) Analogue pins read zero in data
// (R11) Software waits response time after change
// (R12) Control at 1Fh, reference at 9Fh
// (R13) Flag and enable wake from sleep
// (R14) Mismatch with latched outputs sets flag
`timescale 1ns/100ps
module comparator_output_interrupt
    import cmp_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // File register port
    input  wire logic [7:0] addr,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    input  wire logic       rdEn,
    output logic      [7:0] rdData,
    // Analogue comparators
    input  wire logic       cmp1Raw,
    input  wire logic       cmp2Raw,
    output logic      [3:0] cmpConfig,
    output logic      [7:0] vrefConfig,
    // Port A pins 0..4
    input  wire logic [4:0] pinIn,
    input  wire logic [4:0] portLatch,
    output logic            data_a_pin3Out,
    output logic            data_a_pin3Oe,
    output logic            data_a_pin4Out,
    output logic            data_a_pin4Oe,
    output logic      [4:0] analogSel,
    // Core
    output logic            irqRequest,
    output logic            wakeRequest
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic       cmp_irq_enable;
    logic       cmp_irq_flag;
    logic [3:0] comparator_control;
    logic [7:0] voltage_reference_control;
    logic [4:0] data_a_direction;
    logic [1:0] lastOut;
    logic [4:0] pinSync1;
    logic [4:0] pinSync2;
    logic [4:0] pinSync3;
    logic [4:0] pinLevel;
    logic       changed;
    logic [2:0] comparator_mode_field;
    logic       flagsWrite;
    logic       enablesWrite;
    logic       controlWrite;
    logic       vrefWrite;
    logic       dirWrite;
    logic [7:0] flagsByte;
    logic [7:0] enablesByte;
    logic [7:0] controlByte;
    logic [7:0] dataByte;

    cmp_sync_if syncBus();

    assign syncBus.raw = {cmp2Raw, cmp1Raw};

    cmp_sync #(.WIDTH(2)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .port     (syncBus.sync)
    );

    assign comparator_mode_field = comparator_control[2:0];

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    assign flagsWrite   = wrEn && addr == ADDR_FLAGS;   // [R6]
    assign enablesWrite = wrEn && addr == ADDR_ENABLES; // [R6]
    assign controlWrite = wrEn && addr == ADDR_CMPCTL;  // [R12]
    assign vrefWrite    = wrEn && addr == ADDR_VREF;    // [R12]
    assign dirWrite     = wrEn && addr == ADDR_DIR_A;

    // Pins that the comparator mode hands to the analogue side.
    function automatic logic [4:0] analog_pins(input logic [2:0] mode);
        case (mode)
            MODE_OFF:     analog_pins = 5'h00;
            3'h5:         analog_pins = 5'h03;
            MODE_OUTPUTS: analog_pins = 5'h0f;
            default:      analog_pins = 5'h0f;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_irq_enable <= RST_ENABLES[CMP_IRQ_BIT];
        end else if (enablesWrite) begin // [R6]
            cmp_irq_enable <= wrData[CMP_IRQ_BIT]; // [R1] [R5]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            comparator_control <= RST_CMPCTL;
        end else if (controlWrite) begin // [R12]
            comparator_control <= wrData[3:0]; // [R7]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            voltage_reference_control <= RST_VREF;
        end else if (vrefWrite) begin // [R12]
            voltage_reference_control <= wrData & ~(8'h01 << VREF_RSV_BIT);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_a_direction <= RST_DIR_A;
        end else if (dirWrite) begin
            data_a_direction <= wrData[4:0];
        end
    end

    // ---------------------------------------------------------------
    // Change detect; a new change in the clearing cycle wins
    // ---------------------------------------------------------------
    assign changed = syncBus.stable != lastOut; // [R14]

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lastOut <= 2'h0;
        end else begin
            lastOut <= syncBus.stable; // [R14]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_irq_flag <= RST_FLAGS[CMP_IRQ_BIT]; // [R2]
        end else if (changed) begin
            cmp_irq_flag <= 1'b1; // [R3] [R14]
        end else if (flagsWrite) begin // [R6]
            cmp_irq_flag <= wrData[CMP_IRQ_BIT]; // [R2] [R5]
        end
    end

    assign irqRequest  = cmp_irq_flag & cmp_irq_enable;
    // Wake ignores the global enable; the core decides whether to vector.
    assign wakeRequest = cmp_irq_flag & cmp_irq_enable; // [R13]

    // ---------------------------------------------------------------
    // Port A pin sampling and output path
    // ---------------------------------------------------------------
    // A pin level moves only once two sampler stages agree, so a metastable sample never reaches a read.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pinSync1 <= 5'h00;
            pinSync2 <= 5'h00;
            pinSync3 <= 5'h00;
            pinLevel <= 5'h00;
        end else begin
            pinSync1 <= pinIn;
            pinSync2 <= pinSync1;
            pinSync3 <= pinSync2;
            pinLevel <= (pinSync2 & ~(pinSync2 ^ pinSync3)) | (pinLevel & (pinSync2 ^ pinSync3));
        end
    end

    // The raw comparator level goes out unsynchronised, so it can glitch.
    always_comb begin
        if (comparator_mode_field == MODE_OUTPUTS) begin
            data_a_pin3Out = cmp1Raw; // [R8]
            data_a_pin4Out = cmp2Raw; // [R8]
        end else begin
            data_a_pin3Out = portLatch[3];
            data_a_pin4Out = portLatch[4];
        end
    end

    assign data_a_pin3Oe = ~data_a_direction[3]; // [R9]
    assign data_a_pin4Oe = ~data_a_direction[4]; // [R9]
    assign analogSel    = analog_pins(comparator_mode_field);
    assign cmpConfig    = comparator_control;
    assign vrefConfig   = voltage_reference_control;

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    assign flagsByte   = 8'(cmp_irq_flag) << CMP_IRQ_BIT;   // [R2] [R5]
    assign enablesByte = 8'(cmp_irq_enable) << CMP_IRQ_BIT; // [R1] [R5]
    // Result bits come from the sampler, so a read never catches a half-settled level.
    assign controlByte = {syncBus.stable[1], syncBus.stable[0], 2'h0, comparator_control}; // [R7]
    // Analogue pins read zero, which also hides their undefined digital levels.
    assign dataByte    = {3'h0, pinLevel & ~analog_pins(comparator_mode_field)}; // [R10]

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            case (addr)
                ADDR_FLAGS:   rdData <= flagsByte;   // [R5]
                ADDR_ENABLES: rdData <= enablesByte; // [R5]
                ADDR_CMPCTL:  rdData <= controlByte; // [R7]
                ADDR_VREF:    rdData <= voltage_reference_control;
                ADDR_DIR_A:   rdData <= {3'h0, data_a_direction};
                ADDR_DATA_A:  rdData <= dataByte;    // [R10]
                default:      rdData <= 8'h00;
            endcase
        end
    end
endmodule

// File: bench/cmp_out_sva.sv
`timescale 1ns/100ps
module cmp_out_sva
    import cmp_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rstn,
    // File register port
    input wire logic [7:0] addr,
    input wire logic       wrEn,
    input wire logic [7:0] wrData,
    input wire logic       rdEn,
    input wire logic [7:0] rdData,
    // Comparator and pins
    input wire logic       cmp1Raw,
    input wire logic [3:0] cmpConfig,
    input wire logic [4:0] portLatch,
    input wire logic       data_a_pin3Out,
    input wire logic [4:0] analogSel,
    // Core
    input wire logic       irqRequest,
    input wire logic       wakeRequest
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    pin_mux_a: assert property (data_a_pin3Out == ((cmpConfig[2:0] == MODE_OUTPUTS) ? cmp1Raw : portLatch[3]))
        else $error("pin3 mux wrong");
    wake_irq_a: assert property (irqRequest == wakeRequest)
        else $error("wake differs from irq");
    irq_src_a: assert property (rdEn && (addr == ADDR_FLAGS || addr == ADDR_ENABLES) && wakeRequest |=> rdData[6])
        else $error("request without flag and enable");
    flag_mask_a: assert property (rdEn && (addr == ADDR_FLAGS || addr == ADDR_ENABLES) |=> (rdData & 8'hbf) == 8'h00)
        else $error("unimplemented bits set");
    unmapped_rd_a: assert property (rdEn && addr == 8'h20 |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    irq_off_a: assert property (wrEn && addr == ADDR_ENABLES && !wrData[6] |=> !irqRequest)
        else $error("irq after disable");
    ctl_write_a: assert property (wrEn && addr == ADDR_CMPCTL |=> cmpConfig == 4'($past(wrData)))
        else $error("control write lost");
    analog_off_a: assert property (cmpConfig[2:0] == MODE_OFF |-> analogSel == 5'h00)
        else $error("analogue pins in off mode");
    rd_ctl_a: assert property (rdEn && addr == ADDR_CMPCTL |=> rdData[5:4] == 2'h0 && rdData[3:0] == $past(cmpConfig))
        else $error("control read wrong");

    cover property (irqRequest);
    cover property (cmpConfig[2:0] == MODE_OUTPUTS);
    cover property (rdEn && addr == ADDR_DATA_A);
endmodule
bind comparator_output_interrupt cmp_out_sva cmp_out_sva_inst (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .addr          (addr),
    .wrEn          (wrEn),
    .wrData        (wrData),
    .rdEn          (rdEn),
    .rdData        (rdData),
    .cmp1Raw       (cmp1Raw),
    .cmpConfig     (cmpConfig),
    .portLatch     (portLatch),
    .data_a_pin3Out (data_a_pin3Out),
    .analogSel     (analogSel),
    .irqRequest    (irqRequest),
    .wakeRequest   (wakeRequest)
);

// File: bench/cmp_analog_model.sv
`timescale 1ns/100ps
module cmp_analog_model (
    // Requested levels
    input  wire logic [1:0] lvl,
    // Comparator outputs
    output logic            cmp1Raw,
    output logic            cmp2Raw
);
    // Outputs lag the request, so readers must allow settling time.
    assign #1.3 {cmp2Raw, cmp1Raw} = lvl;
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench
    import cmp_pkg::*;
;
    logic       core_clk, rstn, wrEn, rdEn, cmp1Raw, cmp2Raw, irqRequest, wakeRequest;
    logic       data_a_pin3Out, data_a_pin3Oe, data_a_pin4Out, data_a_pin4Oe;
    logic [7:0] addr, wrData, rdData, vrefConfig, d;
    logic [4:0] pinIn, portLatch, analogSel;
    logic [3:0] cmpConfig;
    logic [1:0] lvl;
    int         fail_count, compares, seed;

    comparator_output_interrupt comparator_output_interrupt_inst (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .addr          (addr),
        .wrEn          (wrEn),
        .wrData        (wrData),
        .rdEn          (rdEn),
        .rdData        (rdData),
        .cmp1Raw       (cmp1Raw),
        .cmp2Raw       (cmp2Raw),
        .cmpConfig     (cmpConfig),
        .vrefConfig    (vrefConfig),
        .pinIn         (pinIn),
        .portLatch     (portLatch),
        .data_a_pin3Out (data_a_pin3Out),
        .data_a_pin3Oe  (data_a_pin3Oe),
        .data_a_pin4Out (data_a_pin4Out),
        .data_a_pin4Oe  (data_a_pin4Oe),
        .analogSel     (analogSel),
        .irqRequest    (irqRequest),
        .wakeRequest   (wakeRequest)
    );
    cmp_analog_model cmp_analog_model_inst (.lvl(lvl), .cmp1Raw(cmp1Raw), .cmp2Raw(cmp2Raw));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ---------------------------------------------------------------
    // Tasks and expectations
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t pins %b exp %b", $time, got, exp);
        end
    endtask
    // Each access drops its strobe and lets one edge pass, so back-to-back calls never re-raise in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        wrData = v;
        wrEn = 1'b1;
        @(negedge core_clk);
        wrEn = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rdEn = 1'b1;
        @(negedge core_clk);
        rdEn = 1'b0;
        chk(rdData, e);
        @(negedge core_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    function automatic logic [4:0] analog_exp(logic [2:0] m);
        return (m == MODE_OFF) ? 5'h00 : ((m == 3'h5) ? 5'h03 : 5'h0f);
    endfunction
    function automatic logic [7:0] data_exp(logic [2:0] m, logic [4:0] p);
        return {3'h0, p & ~analog_exp(m)};
    endfunction
    // Reset values, checked after every release of reset.
    task automatic chk_reset;
        rdchk(ADDR_FLAGS, RST_FLAGS);
        rdchk(ADDR_ENABLES, RST_ENABLES);
        rdchk(ADDR_CMPCTL, {4'h0, RST_CMPCTL});
        rdchk(ADDR_VREF, RST_VREF);
        rdchk(ADDR_DIR_A, {3'h0, RST_DIR_A});
        chk({3'h0, analogSel}, {3'h0, analog_exp(MODE_RESET)});
        chk_pin({data_a_pin4Oe, data_a_pin3Oe}, ~RST_DIR_A[4:3]);
        chk_pin({data_a_pin4Out, data_a_pin3Out}, portLatch[4:3]);
    endtask
    task automatic wrap_up;
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 32'hb3f8;
        {rstn, wrEn, rdEn, addr, wrData, lvl, pinIn, portLatch} = '0;
        fail_count = 0;
        compares = 0;
        idle(20);
        rstn = 1'b1;
        chk_reset();
        rdchk(8'h20, 8'h00);
        wr(ADDR_FLAGS, 8'hff);
        wr(ADDR_ENABLES, 8'hff);
        rdchk(ADDR_FLAGS, 8'h40);
        rdchk(ADDR_ENABLES, 8'h40);
        chk({7'h0, irqRequest}, 8'h01);
        wr(ADDR_ENABLES, 8'h00);
        wr(ADDR_FLAGS, 8'h00);
        chk({7'h0, irqRequest}, 8'h00);
        lvl = 2'b01;
        idle(8);
        rdchk(ADDR_FLAGS, 8'h40);
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_ENABLES, 8'h40);
        chk({7'h0, wakeRequest}, 8'h00);
        lvl = 2'b11;
        idle(8);
        chk({7'h0, wakeRequest}, 8'h01);
        // A change and a software clear land on the same edge; the change must win.
        wr(ADDR_FLAGS, 8'h00);
        lvl = 2'b10;
        idle(4);
        wr(ADDR_FLAGS, 8'h00);
        rdchk(ADDR_FLAGS, 8'h40);
        // The first passes force the off, outputs and two-pin modes.
        for (int i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            if (i < 3)
                d[2:0] = 3'(i + 5);
            {lvl, pinIn, portLatch} = 12'($random(seed));
            wr(ADDR_DIR_A, d);
            wr(ADDR_CMPCTL, d);
            wr(ADDR_VREF, ~d);
            idle(8);
            rdchk(ADDR_CMPCTL, {lvl, 2'h0, d[3:0]});
            rdchk(ADDR_VREF, ~d & 8'hef);
            rdchk(ADDR_DATA_A, data_exp(d[2:0], pinIn));
            chk({6'h0, data_a_pin4Oe, data_a_pin3Oe}, {6'h0, ~d[4:3]});
            chk({4'h0, cmpConfig}, {4'h0, d[3:0]});
            chk(vrefConfig, ~d & 8'hef);
            chk({3'h0, analogSel}, {3'h0, analog_exp(d[2:0])});
            chk_pin({data_a_pin4Out, data_a_pin3Out}, (d[2:0] == MODE_OUTPUTS) ? lvl : portLatch[4:3]);
        end
        // A second reset mid-run, with the comparators parked low so no change is pending.
        lvl = 2'b00;
        idle(8);
        rstn = 1'b0;
        idle(2);
        rstn = 1'b1;
        chk_reset();
        wrap_up();
    end

    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule
